//--- core/rdc_pkg.sv
`default_nettype none
package rdc_pkg;

	// Controller clock and the slowest and fastest supported host rates
	localparam int CLK_HZ       = 25_000_000;
	localparam int MIN_BAUD_BPS = 1200;
	localparam int MAX_BAUD_BPS = 115_200;

	// One bit time at the slowest rate, in clock cycles (rounded down)
	localparam int BIT_CYC_MAX = CLK_HZ / MIN_BAUD_BPS;

	// Low pulses shorter than half a bit at the top rate are glitches
	localparam int MIN_PULSE_CYC = CLK_HZ / MAX_BAUD_BPS / 2;

	// Widths of the bit-time and frame counters
	localparam int BT_W  = 15;
	localparam int CNT_W = 19;

	// Character framing: start + 8 data + stop
	localparam int CHAR_BITS = 10;

	// Frame ends mid stop bit, counted in half bits (9.5 bits)
	localparam int FRAME_HALF_BITS = 19;

	// Longest allowed turnaround after a character, in bit times
	localparam int TURN_MAX_BITS_LOW  = 4;
	localparam int TURN_MAX_BITS_MID  = 10;
	localparam int TURN_MAX_BITS_HIGH = 20;

	// Codes on the mode select switch
	localparam logic [1:0] SW_ALWAYS = 2'h0;
	localparam logic [1:0] SW_AUTO   = 2'h1;
	localparam logic [1:0] SW_RTS    = 2'h2;
	localparam logic [1:0] SW_DATA   = 2'h3;

	// Positions on the line option switch (position N is bit N-1)
	localparam int LOPT_W        = 6;
	localparam int LOPT_WIRE_POS = 3;
	localparam int LOPT_WIRE_NEG = 4;
	localparam int LOPT_ECHO_OFF = 5;

	typedef enum logic [3:0] {
		RDC_MODE_ALWAYS = 4'h1,
		RDC_MODE_AUTO   = 4'h2,
		RDC_MODE_RTS    = 4'h4,
		RDC_MODE_DATA   = 4'h8
	} rdc_mode_t;

	typedef enum logic [2:0] {
		RDC_AUTO_IDLE  = 3'h1,
		RDC_AUTO_FRAME = 3'h2,
		RDC_AUTO_GUARD = 3'h4
	} rdc_auto_t;

endpackage
`default_nettype wire

//--- core/rdc_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none
module rdc_skid_buf #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output var  logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr;
	logic [PTR_W-1:0] rptr;
	logic [CNT_W-1:0] count;
	logic             room;
	logic [PTR_W-1:0] next_wptr;
	logic [PTR_W-1:0] next_rptr;
	logic [CNT_W-1:0] next_count;
	logic             next_room;
	logic             push;
	logic             pop;

	always_comb
	begin
		push       = in_valid && room;
		pop        = (count != '0) && out_ready;
		next_wptr  = wptr;
		next_rptr  = rptr;
		next_count = count;
		if (push)
		begin
			next_wptr = (wptr == PTR_W'(DEPTH - 1)) ? '0 : wptr + 1'b1;
		end
		if (pop)
		begin
			next_rptr = (rptr == PTR_W'(DEPTH - 1)) ? '0 : rptr + 1'b1;
		end
		if (push && !pop)
		begin
			next_count = count + 1'b1;
		end
		else if (pop && !push)
		begin
			next_count = count - 1'b1;
		end
		// Ready is registered so the source sees it from a flip-flop
		next_room = (next_count != CNT_W'(DEPTH));
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
			room  <= 1'b1;
		end
		else
		begin
			wptr  <= next_wptr;
			rptr  <= next_rptr;
			count <= next_count;
			room  <= next_room;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wptr] <= in_data;
		end
	end

	assign in_ready  = room;
	assign out_valid = (count != '0);
	assign out_data  = mem[rptr];

endmodule
`default_nettype wire

//--- core/rdc_enable_ctrl.sv
// Summary of operation
// - Data mode: transmit data low enables the line driver.
// - Data mode: transmit data high releases the driver; bias sets idle.
// - RTS mode: driver enable follows host RTS; host holds RTS per message.
// - Auto mode: baud rate measured from transmit stream times the enable.
// - Auto release within 4/10/20 bit times at 38.4K/57.6K/115.2K.
// - Mode switch sampled once after power-up reset, then that mode runs.
// - Later mode switch changes ignored until the next power-up.
// - Transmit data is sampled every cycle ahead of any other work, until DRV_READY low lets the two-entry buffer fill.
// - Echo allowed and two-wire: transmitted characters return to host.
// - Line option position six on suppresses echo, off allows it.
`timescale 1ns/100ps
`default_nettype none
module rdc_enable_ctrl #(
	parameter int BIT_CYC_MAX = rdc_pkg::BIT_CYC_MAX
) (
	input  wire logic                      REF_CLK,
	input  wire logic                      RST_N,
	input  wire logic                      HOST_TXD,
	input  wire logic                      HOST_RTS,
	output var  logic                      HOST_RXD,
	output var  logic                      TXD_READY,
	input  wire logic [1:0]                MODE_SELECT_SWITCH,
	input  wire logic [rdc_pkg::LOPT_W-1:0] LINE_OPTION_SWITCH,
	input  wire logic                      LINE_RXD,
	input  wire logic                      DRV_READY,
	output var  logic                      LINE_TXD,
	output var  logic                      LINE_DRIVE_EN,
	output var  logic                      TX_EN_LED,
	output var  logic                      BAUD_LOCKED
);

	function automatic rdc_pkg::rdc_mode_t decode_mode(input logic [1:0] sw);
		rdc_pkg::rdc_mode_t m;
		m = rdc_pkg::RDC_MODE_ALWAYS;
		case (sw)
			rdc_pkg::SW_AUTO: m = rdc_pkg::RDC_MODE_AUTO;
			rdc_pkg::SW_RTS:  m = rdc_pkg::RDC_MODE_RTS;
			rdc_pkg::SW_DATA: m = rdc_pkg::RDC_MODE_DATA;
			default:          m = rdc_pkg::RDC_MODE_ALWAYS;
		endcase
		return m;
	endfunction

	localparam logic [rdc_pkg::BT_W-1:0] BT_RESET = rdc_pkg::BT_W'(BIT_CYC_MAX);
	localparam logic [rdc_pkg::BT_W-1:0] BT_GLITCH = rdc_pkg::BT_W'(rdc_pkg::MIN_PULSE_CYC);

	// Mode latch
	rdc_pkg::rdc_mode_t mode;
	rdc_pkg::rdc_mode_t next_mode;
	logic               mode_taken;
	logic               next_mode_taken;

	// Auto-enable timing
	rdc_pkg::rdc_auto_t              auto_st;
	rdc_pkg::rdc_auto_t              next_auto_st;
	logic [rdc_pkg::CNT_W-1:0]       cnt;
	logic [rdc_pkg::CNT_W-1:0]       next_cnt;
	logic [rdc_pkg::BT_W-1:0]        bit_time;
	logic [rdc_pkg::BT_W-1:0]        next_bit_time;
	logic [rdc_pkg::BT_W-1:0]        low_cnt;
	logic [rdc_pkg::BT_W-1:0]        next_low_cnt;
	logic                            prev_txd;
	logic                            next_prev_txd;
	logic                            next_locked;
	logic [rdc_pkg::CNT_W-1:0]       frame_len;

	// Outputs
	logic next_line_txd;
	logic next_drive;
	logic next_host_rxd;

	// Sample stream
	logic buf_valid;
	logic buf_data;
	logic buf_ready;
	logic step;
	logic fall;
	logic echo_off;
	logic two_wire;

	// Each cycle's level is captured before any decision is made; with DRV_READY low, capture stops once both entries are full
	rdc_skid_buf #(
		.WIDTH (1),
		.DEPTH (2)
	) u_sample_buf (
		.clk       (REF_CLK),
		.rst_n     (RST_N),
		.in_valid  (1'b1),
		.in_data   (HOST_TXD),
		.in_ready  (buf_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (DRV_READY)
	);

	// Power-up latch: reset stands for power-on, so only a new reset re-reads
	always_comb
	begin
		next_mode       = mode;
		next_mode_taken = mode_taken;
		if (!mode_taken)
		begin
			next_mode       = decode_mode(MODE_SELECT_SWITCH);
			next_mode_taken = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			mode       <= rdc_pkg::RDC_MODE_ALWAYS;
			mode_taken <= 1'b0;
		end
		else
		begin
			mode       <= next_mode;
			mode_taken <= next_mode_taken;
		end
	end

	// Frame lasts to mid stop bit so a back-to-back start edge is still seen
	assign frame_len = rdc_pkg::CNT_W'((32'(bit_time) * rdc_pkg::FRAME_HALF_BITS) >> 1);
	assign step      = buf_valid && DRV_READY;
	assign fall      = prev_txd && !buf_data;

	// Auto mode: shortest clean low pulse is taken as one bit time
	always_comb
	begin
		next_auto_st  = auto_st;
		next_cnt      = cnt;
		next_bit_time = bit_time;
		next_low_cnt  = low_cnt;
		next_prev_txd = prev_txd;
		next_locked   = BAUD_LOCKED;
		if (step)
		begin
			next_prev_txd = buf_data;
			if (!buf_data)
			begin
				if (fall)
				begin
					next_low_cnt = rdc_pkg::BT_W'(1);
				end
				else if (low_cnt != '1)
				begin
					next_low_cnt = low_cnt + 1'b1;
				end
			end
			else if (!prev_txd && low_cnt >= BT_GLITCH && low_cnt < bit_time)
			begin
				next_bit_time = low_cnt;
				next_locked   = 1'b1;
			end
			unique case (auto_st)
				rdc_pkg::RDC_AUTO_IDLE:
				begin
					if (fall)
					begin
						next_auto_st = rdc_pkg::RDC_AUTO_FRAME;
						next_cnt     = '0;
					end
				end
				rdc_pkg::RDC_AUTO_FRAME:
				begin
					// Counts up against the live length, so a lock inside the first character
					// shortens that frame and the next start bit still lands in the guard
					if (cnt >= frame_len - 1'b1)
					begin
						// One bit of hold keeps turnaround well inside the limit
						next_auto_st = rdc_pkg::RDC_AUTO_GUARD;
						next_cnt     = '0;
					end
					else
					begin
						next_cnt = cnt + 1'b1;
					end
				end
				rdc_pkg::RDC_AUTO_GUARD:
				begin
					if (fall)
					begin
						next_auto_st = rdc_pkg::RDC_AUTO_FRAME;
						next_cnt     = '0;
					end
					else if (cnt >= rdc_pkg::CNT_W'(bit_time) - 1'b1)
					begin
						next_auto_st = rdc_pkg::RDC_AUTO_IDLE;
					end
					else
					begin
						next_cnt = cnt + 1'b1;
					end
				end
				default:
				begin
					next_auto_st = rdc_pkg::RDC_AUTO_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			auto_st     <= rdc_pkg::RDC_AUTO_IDLE;
			cnt         <= '0;
			bit_time    <= BT_RESET;
			low_cnt     <= '0;
			prev_txd    <= 1'b1;
			BAUD_LOCKED <= 1'b0;
		end
		else
		begin
			auto_st     <= next_auto_st;
			cnt         <= next_cnt;
			bit_time    <= next_bit_time;
			low_cnt     <= next_low_cnt;
			prev_txd    <= next_prev_txd;
			BAUD_LOCKED <= next_locked;
		end
	end

	assign echo_off = LINE_OPTION_SWITCH[rdc_pkg::LOPT_ECHO_OFF];
	assign two_wire = LINE_OPTION_SWITCH[rdc_pkg::LOPT_WIRE_POS] && LINE_OPTION_SWITCH[rdc_pkg::LOPT_WIRE_NEG];

	// Driver and receive path
	always_comb
	begin
		next_line_txd = LINE_TXD;
		next_drive    = LINE_DRIVE_EN;
		if (step)
		begin
			next_line_txd = buf_data;
		end
		// Decoded from the latch input, so the bus is never driven for a cycle before the mode is known
		unique case (next_mode)
			rdc_pkg::RDC_MODE_ALWAYS: next_drive = 1'b1;
			rdc_pkg::RDC_MODE_AUTO:   next_drive = (next_auto_st != rdc_pkg::RDC_AUTO_IDLE);
			rdc_pkg::RDC_MODE_RTS:    next_drive = HOST_RTS;
			rdc_pkg::RDC_MODE_DATA:
			begin
				if (step)
				begin
					// Bias resistors hold the idle level, so line termination cannot be fitted
					next_drive = !buf_data;
				end
			end
			default:                  next_drive = 1'b1;
		endcase
		if (echo_off && next_drive)
		begin
			next_host_rxd = 1'b1;
		end
		else if (two_wire && next_drive)
		begin
			// Transmit pair is strapped onto the receive pair
			next_host_rxd = next_line_txd;
		end
		else
		begin
			next_host_rxd = LINE_RXD;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			LINE_TXD      <= 1'b1;
			LINE_DRIVE_EN <= 1'b0;
			TX_EN_LED     <= 1'b0;
			HOST_RXD      <= 1'b1;
			TXD_READY     <= 1'b0;
		end
		else
		begin
			LINE_TXD      <= next_line_txd;
			LINE_DRIVE_EN <= next_drive;
			TX_EN_LED     <= next_drive;
			HOST_RXD      <= next_host_rxd;
			TXD_READY     <= buf_ready;
		end
	end

endmodule
`default_nettype wire

//--- verification/rdc_enable_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rdc_enable_ctrl_chk #(
	parameter int BIT_CYC_MAX = rdc_pkg::BIT_CYC_MAX
) (
	input wire logic                       REF_CLK,
	input wire logic                       RST_N,
	input wire logic                       HOST_TXD,
	input wire logic                       HOST_RTS,
	input wire logic                       HOST_RXD,
	input wire logic                       TXD_READY,
	input wire logic [1:0]                 MODE_SELECT_SWITCH,
	input wire logic [rdc_pkg::LOPT_W-1:0] LINE_OPTION_SWITCH,
	input wire logic                       LINE_RXD,
	input wire logic                       DRV_READY,
	input wire logic                       LINE_TXD,
	input wire logic                       LINE_DRIVE_EN,
	input wire logic                       TX_EN_LED,
	input wire logic                       BAUD_LOCKED
);
	logic [1:0]            age;
	logic [1:0]            mode;
	logic [rdc_pkg::CNT_W:0] hi;
	wire                   run = (age == 2'h3);
	// Own copy of the latched mode, so later switch moves cannot leak in
	always_ff @(posedge REF_CLK)
	begin
		age <= !RST_N ? 2'h0 : age + {1'b0, age != 2'h3};
		mode <= (RST_N && age == 2'h0) ? MODE_SELECT_SWITCH : mode;
		hi <= (!RST_N || !HOST_TXD || !DRV_READY) ? '0 : hi + 1'b1;
	end
	sequence s_flow;
		DRV_READY [*4];
	endsequence
	sequence s_stall;
		!DRV_READY [*3];
	endsequence
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	a_led_match: assert property (TX_EN_LED == LINE_DRIVE_EN) else $error("led differs");
	a_always_on: assert property (run && mode == rdc_pkg::SW_ALWAYS |-> LINE_DRIVE_EN)
		else $error("always mode not driving");
	a_data_enable: assert property (s_flow ##0 (run && mode == rdc_pkg::SW_DATA)
		|-> LINE_DRIVE_EN == !$past(HOST_TXD, 2)) else $error("data enable wrong");
	a_txd_path: assert property (s_flow ##0 run |-> LINE_TXD == $past(HOST_TXD, 2))
		else $error("line data wrong");
	a_rts_follow: assert property (run && mode == rdc_pkg::SW_RTS |-> LINE_DRIVE_EN == $past(HOST_RTS))
		else $error("rts enable wrong");
	a_echo_mute: assert property (run && $past(LINE_OPTION_SWITCH[5]) && LINE_DRIVE_EN |-> HOST_RXD)
		else $error("echo not muted");
	a_echo_loop: assert property (run && $past(LINE_OPTION_SWITCH[5:3]) == 3'h3 && LINE_DRIVE_EN
		|-> HOST_RXD == LINE_TXD) else $error("echo missing");
	a_rx_pass: assert property (run && !LINE_DRIVE_EN |-> HOST_RXD == $past(LINE_RXD))
		else $error("receive path wrong");
	// Last low ends one bit into a character at the earliest: stop end plus 4 bits is 13 bits on
	a_auto_release: assert property (run && mode == rdc_pkg::SW_AUTO && hi >= 13 * BIT_CYC_MAX
		|-> !LINE_DRIVE_EN) else $error("auto release late");
	a_stall_full: assert property (s_stall |=> !TXD_READY) else $error("stall not flagged");
	a_reset_state: assert property (disable iff (1'b0) !RST_N |=> !LINE_DRIVE_EN && HOST_RXD
		&& LINE_TXD && !TXD_READY && !BAUD_LOCKED) else $error("reset state wrong");
endmodule
bind rdc_enable_ctrl rdc_enable_ctrl_chk #(.BIT_CYC_MAX(BIT_CYC_MAX)) rdc_enable_ctrl_chk_inst (.*);
`default_nettype wire

//--- verification/rdc_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module rdc_line_model (
	input  wire logic clk,
	input  wire logic stall,
	input  wire logic line_txd,
	input  wire logic drive_en,
	output var  logic line_rxd,
	output var  logic drv_ready
);
	// A released line floats to the bias level, never to the last bit
	always_comb line_rxd = drive_en ? line_txd : 1'b1;
	always_ff @(posedge clk) drv_ready <= !stall;
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {int due; int sel; logic exp;} rdc_note_t;
	localparam int BIT = 400;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       txd = 1'b1;
	logic       rts = 1'b0;
	logic [1:0] msw = 2'h0;
	logic [5:0] lsw = 6'h00;
	logic       stall = 1'b0;
	wire logic  rxd, txrdy, lrxd, drdy, ltxd, en, led, lock;
	int         miscompares = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         seed = 81102;
	rdc_note_t  q[$];
	string      nm[6] = '{"drive_en", "led", "line_txd", "host_rxd", "txd_ready", "baud_locked"};
	always #20 clk = ~clk;
	rdc_enable_ctrl #(.BIT_CYC_MAX(500)) rdc_enable_ctrl_inst (.REF_CLK(clk), .RST_N(rst_n),
		.HOST_TXD(txd), .HOST_RTS(rts), .HOST_RXD(rxd), .TXD_READY(txrdy), .MODE_SELECT_SWITCH(msw),
		.LINE_OPTION_SWITCH(lsw), .LINE_RXD(lrxd), .DRV_READY(drdy), .LINE_TXD(ltxd),
		.LINE_DRIVE_EN(en), .TX_EN_LED(led), .BAUD_LOCKED(lock));
	rdc_line_model rdc_line_model_inst (.clk(clk), .stall(stall), .line_txd(ltxd), .drive_en(en),
		.line_rxd(lrxd), .drv_ready(drdy));
	function automatic logic pick(int s);
		logic v[6];
		v = '{en, led, ltxd, rxd, txrdy, lock};
		return v[s];
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic note(int d, int s, logic e);
		q.push_back(rdc_note_t'{cyc + d, s, e});
	endtask
	task automatic cmp(int s, logic e);
		total_checks++;
		if (pick(s) !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", nm[s], e, pick(s));
		end
	endtask
	always @(negedge clk)
	begin
		cyc++;
		while (q.size() > 0 && q[0].due <= cyc)
		begin
			cmp(q[0].sel, q[0].exp);
			void'(q.pop_front());
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic power_up(logic [1:0] m, logic [5:0] l);
		// Pending notes belong to the old mode and must be seen before reset wipes the outputs
		while (q.size() != 0)
			tick(1);
		rst_n <= 1'b0;
		tick(10);
		msw <= m;
		lsw <= l;
		txd <= 1'b1;
		rst_n <= 1'b1;
		tick(6);
	endtask
	task automatic run(int n, logic [1:0] m);
		logic b, r;
		repeat (n)
		begin
			b = 1'($random(seed));
			r = 1'($random(seed));
			txd <= b;
			rts <= r;
			if (m == rdc_pkg::SW_DATA)
			begin
				note(3, 0, !b);
				if (!b)
					note(3, 3, 1'b1);
			end
			else if (m == rdc_pkg::SW_RTS)
				note(2, 1, r);
			else
			begin
				note(3, 0, 1'b1);
				note(3, 2, b);
				note(3, 3, b);
			end
			tick(1);
		end
	endtask
	task automatic send_char(logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			txd <= f[i];
			if (i == 1)
				note(3, 0, 1'b1);
			tick(BIT);
		end
	endtask
	initial
	begin
		tick(60000);
		miscompares++;
		wrap_up();
	end
	initial
	begin
		power_up(rdc_pkg::SW_ALWAYS, 6'h18);
		run(30, rdc_pkg::SW_ALWAYS);
		msw <= rdc_pkg::SW_DATA;
		run(30, rdc_pkg::SW_ALWAYS);
		$display("test always_on done");
		power_up(rdc_pkg::SW_DATA, 6'h38);
		run(40, rdc_pkg::SW_DATA);
		stall <= 1'b1;
		tick(6);
		note(1, 4, 1'b0);
		stall <= 1'b0;
		tick(8);
		note(1, 4, 1'b1);
		tick(2);
		$display("test data_enable done");
		power_up(rdc_pkg::SW_RTS, 6'h00);
		run(40, rdc_pkg::SW_RTS);
		$display("test rts_enable done");
		power_up(rdc_pkg::SW_AUTO, 6'h18);
		// Isolated start bit trains the rate detector on the first character
		send_char(8'h55);
		send_char(8'($random(seed)));
		tick(3 * BIT);
		note(1, 0, 1'b0);
		note(1, 5, 1'b1);
		// Idle long enough for the checker's release window to open
		tick(13 * BIT);
		$display("test auto_enable done");
		wrap_up();
	end
endmodule
`default_nettype wire
